// ---- rtl/ssl_consts.vh ----
`ifndef SSL_CONSTS_VH
`define SSL_CONSTS_VH
// Select-mode field encodings.
`define SSL_MODE_3WIRE 2'h0
`define SSL_MODE_MULTI 2'h1
// Top bit of the select-mode field: set means select pin is an output.
`define SSL_MODE_OUT_BIT 1
// Bits per transfer and bit counter width.
`define SSL_BITS 4'h8
`define SSL_CNT_W 4
// Reset value of the select-mode field.
`define SSL_RST_MODE 2'h1
// Master clock divider: half period of the generated serial clock in core cycles.
`define SSL_SCK_HALF 8'h04
`endif

// ---- rtl/ssl_sync.v ----
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs; the first flop feeds only the second.
module ssl_sync (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_async,
  output wire o_sync
);
  // First and second stage flops.
  reg meta_reg;
  reg sync_reg;

  // Both stages reset to zero so the pin settles before use.
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule // ssl_sync

// ---- rtl/ssl_edge.v ----
`timescale 1ns/1ps
// Edge detector on an already synchronised level.
module ssl_edge (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_level,
  output wire o_rise,
  output wire o_fall
);
  // Previous sample of the level.
  reg prev_reg;

  // Reset value one matches an idle-high select line and avoids a false fall.
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= i_level;
    end
  end

  assign o_rise = i_level & ~prev_reg;
  assign o_fall = ~i_level & prev_reg;
endmodule // ssl_edge

// ---- rtl/ssl_port.v ----
`timescale 1ns/1ps
`include "ssl_consts.vh"
// Functional notes
// - Master drives data-out line, slave receives it.
// - Master receives data-in line, slave drives it.
// - Shift MSB first; master output is top bit.
// - Data-in line floats when disabled or unselected.
// - Three-wire slave always drives top bit.
// - Master makes serial clock; slave uses external.
// - Unselected four-wire slave ignores serial clock.
// - Mode 00: three-wire, slave always selected.
// - Mode 01: select pin input selects slave.
// - Mode 01 master: select fall disables master.
// - Mode 1x: select pin outputs low bit while port enabled.
// - Select pin routed except in mode 00.
// - Master flag set means master, else slave.
// - Mode fault clears both enables, sets fault.
// - Mode 01: select fall clears slave bit counter unless a clock rise samples that cycle.
// - Eight slave bits set done, load receive.
module ssl_port (
  input wire i_core_clk,
  input wire i_rst_b,
  // Software control of the enables; set pulses, clear pulses.
  input wire i_port_enable_set,
  input wire i_port_enable_clr,
  input wire i_master_enable_set,
  input wire i_master_enable_clr,
  // Select-mode field, a plain level from software.
  input wire [1:0] i_select_mode_field,
  // Transmit byte and its load strobe.
  input wire [7:0] i_tx_data,
  input wire i_tx_load,
  // Flag clear pulses from software.
  input wire i_transfer_done_clr,
  input wire i_mode_fault_clr,
  // Serial pins.
  input wire i_mosi,
  output wire o_mosi,
  output wire o_mosi_oe,
  input wire i_miso,
  output wire o_miso,
  output wire o_miso_oe,
  input wire i_sck,
  output wire o_sck,
  output wire o_sck_oe,
  input wire i_slave_select_pin,
  output wire o_slave_select_pin,
  output wire o_slave_select_pin_oe,
  output wire o_slave_select_routed,
  // Status.
  output wire o_port_enable_flag,
  output wire o_master_enable_flag,
  output wire o_mode_fault_flag,
  output wire o_transfer_done_flag,
  output wire [7:0] o_rx_data,
  output wire o_busy
);
  // Synchronised pin levels.
  wire mosi_s;
  wire miso_s;
  wire sck_s;
  // Inverted select level out of its synchroniser; it resets low, so the pin level below resets high.
  wire sel_inv_s;
  // Synchronised select pin level; it idles high, so reset must leave it high as well.
  wire sel_pin_s;
  // Rising edge of the synchronised serial clock; its falling edge is not used.
  wire sck_rise;
  // Falling edge of the synchronised select pin; its rising edge is not used.
  wire sel_fall;
  // Control and status flags.
  reg port_en_reg;
  reg master_en_reg;
  reg mode_fault_reg;
  reg done_reg;
  // Shared shift register, bit counter and receive buffer.
  reg [7:0] shift_reg;
  reg [`SSL_CNT_W-1:0] cnt_reg;
  reg [7:0] rx_reg;
  // Master engine state.
  reg busy_reg;
  reg sck_out_reg;
  reg [7:0] div_reg;
  // Data-in bit taken on the rising serial clock, shifted in on the following fall.
  reg miso_bit_reg;
  // Mode decode.
  wire is_master;
  wire is_slave;
  wire mode_3w;
  wire mode_multi;
  wire mode_out;
  wire selected;
  wire fault_evt;
  wire slave_sample;
  wire slave_done;
  wire master_tick;

  // Each pin input passes two flops before the logic reads it.
  ssl_sync u_sync_mosi (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_async(i_mosi), .o_sync(mosi_s));
  ssl_sync u_sync_miso (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_async(i_miso), .o_sync(miso_s));
  ssl_sync u_sync_sck (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_async(i_sck), .o_sync(sck_s));
  // The select pin is inverted around its synchroniser so that reset reads as deselected.
  // A plain zero reset here would look like a select fall on the first edges after reset.
  ssl_sync u_sync_sel (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_async(~i_slave_select_pin),
    .o_sync(sel_inv_s));
  assign sel_pin_s = ~sel_inv_s;

  // Edge finders on the synchronised levels.
  // Only rising clock edges are used, so the idle-low clock needs no reset match of its own.
  ssl_edge u_edge_sck (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_level(sck_s), .o_rise(sck_rise),
    .o_fall());
  ssl_edge u_edge_sel (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_level(sel_pin_s), .o_rise(),
    .o_fall(sel_fall));

  // A disabled port is neither master nor slave, so a mode fault leaves it fully idle.
  // Software must raise both enables again before the master can run once more.
  // master or slave
  assign is_master = port_en_reg & master_en_reg;
  assign is_slave = port_en_reg & ~master_en_reg;

  assign mode_3w = (i_select_mode_field == `SSL_MODE_3WIRE);
  assign mode_multi = (i_select_mode_field == `SSL_MODE_MULTI);
  assign mode_out = i_select_mode_field[`SSL_MODE_OUT_BIT];

  // always selected; pin selects when low.
  // In mode 1x the port never counts itself selected, since that setting is meant for a master.
  assign selected = mode_3w | (mode_multi & ~sel_pin_s);

  // A fall is seen about two core cycles after the pin moves, through the synchroniser.
  // select fall disables master
  assign fault_evt = is_master & mode_multi & sel_fall;

  // slave paced by external clock
  // Sampling on the rising serial clock edge is fixed; phase and polarity are not supported.
  assign slave_sample = is_slave & selected & sck_rise;
  assign slave_done = slave_sample & (cnt_reg == `SSL_BITS - 4'h1);

  // Master bit tick at each divider wrap.
  // One half period of the serial clock lasts SSL_SCK_HALF core cycles.
  // A byte takes sixteen half periods: eight rises to sample and eight falls to shift.
  assign master_tick = is_master & busy_reg & (div_reg == `SSL_SCK_HALF - 8'h01);

  // Enable flags; the fault clear wins because it must stop a contending master at once.
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port_en_reg <= 1'b0;
      master_en_reg <= 1'b0;
    end else begin
      if (fault_evt) begin
        port_en_reg <= 1'b0;
        master_en_reg <= 1'b0;
      end else begin
        if (i_port_enable_set) begin
          port_en_reg <= 1'b1;
        end else if (i_port_enable_clr) begin
          port_en_reg <= 1'b0;
        end
        if (i_master_enable_set) begin
          master_en_reg <= 1'b1;
        end else if (i_master_enable_clr) begin
          master_en_reg <= 1'b0;
        end
      end
    end
  end

  // Sticky fault and done flags; a hardware set wins over a software clear.
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_fault_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (fault_evt) begin
        mode_fault_reg <= 1'b1;
      end else if (i_mode_fault_clr) begin
        mode_fault_reg <= 1'b0;
      end
      if (slave_done | (master_tick & sck_out_reg & (cnt_reg == `SSL_BITS - 4'h1))) begin
        done_reg <= 1'b1;
      end else if (i_transfer_done_clr) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Shift register, bit counter, receive buffer and master clock engine.
  // The slave samples and shifts on the rising serial clock; the external master sees the new
  // top bit a few core cycles later, well before its next rising edge.
  // The master samples on the rising edge it makes and shifts on the falling one.
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      busy_reg <= 1'b0;
      sck_out_reg <= 1'b0;
      div_reg <= 8'h00;
      miso_bit_reg <= 1'b0;
    end else if (!port_en_reg) begin
      // Disabling the port is the only way to restart a three-wire slave count.
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      sck_out_reg <= 1'b0;
      div_reg <= 8'h00;
      if (i_tx_load) begin
        shift_reg <= i_tx_data;
      end
    end else if (is_slave) begin
      if (slave_sample) begin
        shift_reg <= {shift_reg[6:0], mosi_s};
        if (slave_done) begin
          cnt_reg <= 4'h0;
          rx_reg <= {shift_reg[6:0], mosi_s};
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end else if (mode_multi & sel_fall) begin
        cnt_reg <= 4'h0;
      end else if (i_tx_load & (cnt_reg == 4'h0)) begin
        // Load is taken only between bytes so a transfer in flight stays intact.
        shift_reg <= i_tx_data;
      end
    end else begin
      if (!busy_reg) begin
        if (i_tx_load) begin
          shift_reg <= i_tx_data;
          busy_reg <= 1'b1;
          cnt_reg <= 4'h0;
          div_reg <= 8'h00;
        end
      end else if (master_tick) begin
        div_reg <= 8'h00;
        sck_out_reg <= ~sck_out_reg;
        if (!sck_out_reg) begin
          // master samples MSB first
          // The bit is only held here; shifting now would move the data-out line in the
          // very step in which the far slave samples it.
          miso_bit_reg <= miso_s;
        end else begin
          // Shift on the falling edge so the next bit has a full half period to settle.
          shift_reg <= {shift_reg[6:0], miso_bit_reg};
          if (cnt_reg == `SSL_BITS - 4'h1) begin
            // Last falling edge: the byte is complete and the clock rests low again.
            busy_reg <= 1'b0;
            cnt_reg <= 4'h0;
            rx_reg <= {shift_reg[6:0], miso_bit_reg};
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  // Both data lines show the top shift bit at all times; only the enables decide whether a
  // pin is driven, so the pad logic alone keeps two drivers off one line.
  // data-out direction
  assign o_mosi = shift_reg[7];
  assign o_mosi_oe = is_master;

  assign o_miso = shift_reg[7];
  assign o_miso_oe = is_slave & selected;

  assign o_sck = sck_out_reg;
  assign o_sck_oe = is_master;

  assign o_slave_select_pin = i_select_mode_field[0];
  assign o_slave_select_pin_oe = port_en_reg & mode_out;

  assign o_slave_select_routed = ~mode_3w;

  // Status outputs.
  // The receive byte is overwritten by every completed transfer; no overrun is reported.
  assign o_port_enable_flag = port_en_reg;
  assign o_master_enable_flag = master_en_reg;
  assign o_mode_fault_flag = mode_fault_reg;
  assign o_transfer_done_flag = done_reg;
  assign o_rx_data = rx_reg;
  assign o_busy = busy_reg;
endmodule // ssl_port

// ---- tb/ssl_port_props.sv ----
`timescale 1ns/1ps
// Pin direction, select routing and fault checks on the serial port.
module ssl_port_props (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire [1:0] i_select_mode_field,
  input wire i_slave_select_pin,
  input wire o_mosi_oe,
  input wire o_miso_oe,
  input wire o_sck_oe,
  input wire o_slave_select_pin,
  input wire o_slave_select_pin_oe,
  input wire o_slave_select_routed,
  input wire o_port_enable_flag,
  input wire o_master_enable_flag,
  input wire o_mode_fault_flag,
  input wire o_transfer_done_flag
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire en_m = o_port_enable_flag && o_master_enable_flag; // Enabled master.
  wire en_s = o_port_enable_flag && !o_master_enable_flag; // Enabled slave.
  wire m01 = i_select_mode_field == 2'h1; // Multi-master select input.
  // Armed master sees the select line fall.
  sequence s_arm; m01 && en_m && $fell(i_slave_select_pin); endsequence
  // Both enables down and the fault raised.
  sequence s_fault; o_mode_fault_flag && !o_port_enable_flag && !o_master_enable_flag; endsequence
  a_mosi_drive_master: assert property (o_mosi_oe == en_m) else $error("mosi enable wrong");
  a_miso_drive_slave: assert property (o_miso_oe |-> en_s) else $error("miso driven off slave");
  a_miso_float_off: assert property (!o_port_enable_flag |-> !o_miso_oe) else $error("miso driven off");
  a_miso_float_unsel: assert property ((m01 && i_slave_select_pin) [*4] |-> !o_miso_oe)
    else $error("miso driven unselected");
  a_miso_three_wire: assert property (en_s && i_select_mode_field == 2'h0 |-> o_miso_oe)
    else $error("three wire slave not driving");
  a_sck_drive_master: assert property (o_sck_oe == en_m) else $error("sck enable wrong");
  a_sck_ignored: assert property ((m01 && en_s && i_slave_select_pin) [*6] |-> !$rose(o_transfer_done_flag))
    else $error("unselected slave finished");
  a_select_input: assert property (!i_select_mode_field[1] |-> !o_slave_select_pin_oe) else $error("select driven");
  a_fault_trip: assert property (s_arm |-> ##[1:6] s_fault) else $error("no mode fault");
  a_select_output: assert property (i_select_mode_field[1] && o_port_enable_flag |->
    o_slave_select_pin_oe && o_slave_select_pin == i_select_mode_field[0]) else $error("select output wrong");
  a_select_routing: assert property (o_slave_select_routed == (i_select_mode_field != 2'h0))
    else $error("select routing wrong");
endmodule // ssl_port_props

// ---- tb/ssl_far_end.sv ----
`timescale 1ns/1ps
// Far side: an outside master pacing the block, or the sole slave of the block as master.
module ssl_far_end (
  input wire i_sck_in,
  input wire i_mosi_in,
  input wire i_miso_in,
  output reg o_sck,
  output reg o_mosi,
  output reg o_miso
);
  reg [7:0] sl_tx_reg; // Byte returned when acting as slave.
  reg [7:0] sl_rx_reg; // Byte captured when acting as slave.
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_miso = 1'b0;
    sl_tx_reg = 8'h00;
    sl_rx_reg = 8'h00;
  end
  always @(posedge i_sck_in) begin
    sl_rx_reg = {sl_rx_reg[6:0], i_mosi_in};
  end
  // Fill with inverted bits so a stale line never looks valid.
  always @(negedge i_sck_in) begin
    sl_tx_reg = {sl_tx_reg[6:0], ~sl_tx_reg[7]};
    o_miso = sl_tx_reg[7];
  end
  task arm(input [7:0] b);
    begin
      sl_tx_reg = b;
      o_miso = b[7];
    end
  endtask
  task xfer(input integer n, input [7:0] b, output [7:0] got);
    integer i;
    begin
      got = 8'h00;
      for (i = 7; i > 7 - n; i = i - 1) begin
        o_mosi = b[i];
        #62.5 o_sck = 1'b1;
        got = {got[6:0], i_miso_in};
        #62.5 o_sck = 1'b0;
      end
      #62.5 o_mosi = ~o_mosi;
    end
  endtask
endmodule // ssl_far_end

// ---- tb/test_spi_signal_select_logic.sv ----
`timescale 1ns/1ps
// Directed bench: slave in both select modes, master with select output, mode fault.
module test_spi_signal_select_logic;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [6:0] ctl = 7'h00; // Set/clear/load pulses, packed.
  reg [1:0] mode = 2'h0;
  reg [7:0] tx = 8'h00;
  reg ss = 1'b1;
  reg [7:0] got;
  integer err_total = 0;
  integer total_checks = 0;
  integer n;
  wire mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_o, ss_oe, routed;
  wire pe, me, fault, done, busy, f_sck, f_mosi, f_miso;
  wire [7:0] rx;
  always #5 core_clk = ~core_clk;
  ssl_port i_ssl_port (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_port_enable_set(ctl[6]),
    .i_port_enable_clr(ctl[5]), .i_master_enable_set(ctl[4]), .i_master_enable_clr(ctl[3]),
    .i_select_mode_field(mode), .i_tx_data(tx), .i_tx_load(ctl[2]), .i_transfer_done_clr(ctl[1]),
    .i_mode_fault_clr(ctl[0]), .i_mosi(f_mosi), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe), .i_miso(f_miso),
    .o_miso(miso_o), .o_miso_oe(miso_oe), .i_sck(f_sck), .o_sck(sck_o), .o_sck_oe(sck_oe),
    .i_slave_select_pin(ss), .o_slave_select_pin(ss_o), .o_slave_select_pin_oe(ss_oe),
    .o_slave_select_routed(routed), .o_port_enable_flag(pe), .o_master_enable_flag(me),
    .o_mode_fault_flag(fault), .o_transfer_done_flag(done), .o_rx_data(rx), .o_busy(busy));
  // A released data line shows the inverse of its last value, so a float never looks valid.
  ssl_far_end i_ssl_far_end (.i_sck_in(sck_o), .i_mosi_in(mosi_oe ? mosi_o : ~mosi_o),
    .i_miso_in(miso_oe ? miso_o : ~miso_o),
    .o_sck(f_sck), .o_mosi(f_mosi), .o_miso(f_miso));
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task pulse(input [6:0] m);
    begin
      @(negedge core_clk) ctl = m;
      @(negedge core_clk) ctl = 7'h00;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Whole run is a few hundred cycles; this limit is far beyond it.
  initial begin
    #200000;
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    chk("reset", {pe, me, miso_oe, mosi_oe, sck_oe}, 8'h00);
    pulse(7'h40);
    tx = 8'hA5;
    pulse(7'h04);
    chk("slv3w", {miso_oe, routed, mosi_oe}, 8'h04);
    i_ssl_far_end.xfer(8, 8'h3C, got);
    repeat (4) @(negedge core_clk);
    chk("rx3w", rx, 8'h3C);
    chk("done3w", done, 8'h01);
    chk("out3w", got, 8'hA5);
    pulse(7'h02);
    mode = 2'h1;
    repeat (4) @(negedge core_clk);
    chk("unsel", {miso_oe, routed}, 8'h01);
    i_ssl_far_end.xfer(8, 8'h0F, got);
    repeat (4) @(negedge core_clk);
    chk("ignore", rx, 8'h3C);
    chk("igndone", done, 8'h00);
    ss = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("sel", miso_oe, 8'h01);
    i_ssl_far_end.xfer(3, 8'hFF, got);
    @(negedge core_clk);
    ss = 1'b1;
    repeat (5) @(negedge core_clk);
    ss = 1'b0;
    repeat (5) @(negedge core_clk);
    i_ssl_far_end.xfer(8, 8'hC3, got);
    repeat (4) @(negedge core_clk);
    chk("rxsel", rx, 8'hC3);
    chk("donesel", done, 8'h01);
    pulse(7'h02);
    mode = 2'h2;
    pulse(7'h10);
    i_ssl_far_end.arm(8'hE7);
    tx = 8'h5A;
    pulse(7'h04);
    chk("mstpins", {mosi_oe, sck_oe, miso_oe, ss_oe, ss_o, routed}, 8'h35);
    chk("busy", busy, 8'h01);
    for (n = 0; n < 200 && busy; n = n + 1) @(negedge core_clk);
    chk("idle", busy, 8'h00);
    chk("mstrx", rx, 8'hE7);
    chk("mstout", i_ssl_far_end.sl_rx_reg, 8'h5A);
    chk("mstdone", done, 8'h01);
    mode = 2'h3;
    @(negedge core_clk);
    chk("ssout", ss_o, 8'h01);
    ss = 1'b1;
    mode = 2'h1;
    repeat (5) @(negedge core_clk);
    chk("armed", {pe, me, fault}, 8'h06);
    ss = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("fault", {pe, me, fault, mosi_oe}, 8'h02);
    pulse(7'h01);
    chk("fclr", fault, 8'h00);
    tally_and_finish;
  end
endmodule // test_spi_signal_select_logic
bind ssl_port ssl_port_props i_ssl_port_props (.i_core_clk, .i_rst_b, .i_select_mode_field,
  .i_slave_select_pin, .o_mosi_oe, .o_miso_oe, .o_sck_oe, .o_slave_select_pin, .o_slave_select_pin_oe,
  .o_slave_select_routed, .o_port_enable_flag, .o_master_enable_flag, .o_mode_fault_flag,
  .o_transfer_done_flag);
